// ### common/icp_pkg.sv
// Constants and types shared by the inverter current-mode PI controller
package icp_pkg;
  // Clock and loop timing
  localparam int unsigned ICP_CLK_HZ = 200_000_000;
  localparam int unsigned ICP_CUR_LOOP_NS = 50_000;
  localparam int unsigned ICP_VOL_LOOP_NS = 100_000;
  // Half carrier period in cycles: up ramp plus down ramp is one loop
  localparam int unsigned ICP_CARRIER_HALF =
    ICP_CUR_LOOP_NS * (ICP_CLK_HZ / 1_000_000) / 1000 / 2;
  localparam int unsigned ICP_VOL_DIV = ICP_VOL_LOOP_NS / ICP_CUR_LOOP_NS;
  localparam int unsigned ICP_CNT_W = 16;
  // Sense code layout
  localparam logic [15:0] ICP_ADC_ZERO = 16'h7FC0;
  localparam logic [15:0] ICP_ADC_POS_FULL = 16'h0000;
  localparam logic [15:0] ICP_ADC_NEG_FULL = 16'hFFC0;
  // Current regulator coefficients and fractional formats
  localparam logic signed [15:0] ICP_CUR_KP = 16'sh0400;
  localparam logic signed [15:0] ICP_CUR_KI = 16'sh01E2;
  localparam logic signed [15:0] ICP_CUR_KC = 16'sh0F12;
  localparam int ICP_CUR_QP = 9;
  localparam int ICP_CUR_QI = 9;
  localparam int ICP_CUR_QC = 13;
  // Voltage regulator coefficients and fractional formats
  localparam logic signed [15:0] ICP_VOL_KP = 16'sh7FFF;
  localparam logic signed [15:0] ICP_VOL_KI = 16'sh0507;
  localparam logic signed [15:0] ICP_VOL_KC = 16'sh0507;
  localparam int ICP_VOL_QP = 15;
  localparam int ICP_VOL_QI = 12;
  localparam int ICP_VOL_QC = 12;
  // Default output limits
  localparam logic signed [15:0] ICP_VOL_UPPER_LIMIT = 16'sh4000;
  localparam logic signed [15:0] ICP_VOL_LOWER_LIMIT = -16'sh4000;
  localparam logic signed [15:0] ICP_CUR_UPPER_LIMIT = 16'sh2000;
  localparam logic signed [15:0] ICP_CUR_LOWER_LIMIT = -16'sh2000;
  // Command to compare scaling, sine reference defaults and dead-time counter ceiling
  localparam int ICP_CMP_SHIFT = 2;
  localparam logic signed [15:0] ICP_SINE_AMP = 16'sh6000;
  localparam logic [15:0] ICP_PHASE_INC = 16'h0148;
  localparam logic [7:0] ICP_DT_MAX = 8'hFF;
  // Regulator sequencing states
  typedef enum logic [1:0] {
    ICP_PI_IDLE = 2'b00,
    ICP_PI_RAW = 2'b01,
    ICP_PI_INTEG = 2'b10
  } icp_pi_state_e;
endpackage : icp_pkg

// ### dv/icp_plant_model.sv
// Sense converter and power switch model at the controller's far side
`timescale 1ns/1ps
`default_nettype none
module icp_plant_model #(
  parameter int P_CONV = 7
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Analog levels given as raw codes
  input wire logic [15:0] i_volt_code,
  input wire logic [15:0] i_curr_code,
  // Switch gate drive
  input wire logic i_high_side_gate,
  input wire logic i_low_side_gate,
  // Converter result registers
  output logic [15:0] o_voltage_sense_channel,
  output logic [15:0] o_current_sense_channel,
  // On-time of each switch since reset
  output logic [15:0] o_hi_on,
  output logic [15:0] o_lo_on
);
  int conv_r; // Cycles into the running conversion
  // Results refresh only when a conversion ends, ten bits left aligned,
  // so the controller sees stale codes just as with a real converter
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      conv_r <= 0;
      o_voltage_sense_channel <= 16'h7FC0;
      o_current_sense_channel <= 16'h7FC0;
      o_hi_on <= 16'h0000;
      o_lo_on <= 16'h0000;
    end else begin
      conv_r <= (conv_r == P_CONV - 1) ? 0 : conv_r + 1;
      if (conv_r == P_CONV - 1) begin
        o_voltage_sense_channel <= i_volt_code & 16'hFFC0;
        o_current_sense_channel <= i_curr_code & 16'hFFC0;
      end
      // Each switch conducts while its gate is high
      o_hi_on <= o_hi_on + {15'h0000, i_high_side_gate};
      o_lo_on <= o_lo_on + {15'h0000, i_low_side_gate};
    end
  end
endmodule : icp_plant_model
`default_nettype wire

// ### dv/inverter_current_mode_pi_control_tb.sv
// Self-checking bench for the two-loop inverter PWM controller
`timescale 1ns/1ps
`default_nettype none
module inverter_current_mode_pi_control_tb;
  import icp_pkg::*;
  localparam int HALF = 20; // Short carrier keeps the run brief
  localparam int PER = 2 * HALF;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [15:0] vcode, ccode, vs, cs, cmp, hi_on, lo_on, cmp_l, e_cmp;
  logic [15:0] snap; // Off switch on-time at the start of a settled window
  logic signed [15:0] cmd, vref, cmd_l, ref_l, e_cmd;
  logic [7:0] dead;
  logic hi, lo, uf;
  logic [3:0] uh; // Recent underflows
  // Voltage turns; deep enough to span the regulator latency
  logic [5:0] vh;
  logic [31:0] rng = 32'h0000_4E2B;
  int failures = 0;
  int total_checks = 0;
  int cyc = 0;
  int gap, ufn, run, side_l;
  // Saturating corners: voltage code and current code per case
  logic [15:0] vt[4] = '{16'hFFC0, 16'h0000, 16'hFFC0, 16'h0000};
  logic [15:0] ct[4] = '{16'h5FC0, 16'h5FC0, 16'hFFC0, 16'h0000};
  logic [7:0] dts[4] = '{8'h00, 8'h01, 8'h07, 8'h03};

  icp_plant_model plant_u (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_volt_code(vcode),
    .i_curr_code(ccode), .i_high_side_gate(hi), .i_low_side_gate(lo),
    .o_voltage_sense_channel(vs), .o_current_sense_channel(cs),
    .o_hi_on(hi_on), .o_lo_on(lo_on));
  icp_inverter_ctrl #(.P_CARRIER_HALF(HALF)) dut_u (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_voltage_sense_channel(vs), .i_current_sense_channel(cs),
    .i_dead_time_control(dead), .o_high_side_gate(hi),
    .o_low_side_gate(lo), .o_inverter_compare_value(cmp),
    .o_current_command(cmd), .o_voltage_reference(vref),
    .o_carrier_underflow(uf));

  // Clock generator
  initial begin
    forever #2.5 i_clk = ~i_clk;
  end

  // Single comparison point
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Verdict and end of run
  task automatic close_out();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  // A code above the offset is a negative level, so the error is positive
  function automatic logic signed [15:0] exp_cmd(input logic [15:0] vc);
    return (vc > ICP_ADC_ZERO) ? ICP_VOL_UPPER_LIMIT : ICP_VOL_LOWER_LIMIT;
  endfunction : exp_cmd

  // Current error sign decides which limit the current loop sits on
  function automatic logic signed [15:0] exp_cur(
    input logic signed [15:0] c, input logic [15:0] cc);
    int e;
    e = int'(c) - (int'(ICP_ADC_ZERO) - int'(cc));
    return (e > 0) ? ICP_CUR_UPPER_LIMIT : ICP_CUR_LOWER_LIMIT;
  endfunction : exp_cur

  // Regulator output to carrier compare, held inside the carrier span
  function automatic logic [15:0] exp_cmp(input logic signed [15:0] u);
    int c;
    c = HALF / 2 + (int'(u) >>> ICP_CMP_SHIFT);
    if (c < 0) c = 0;
    if (c > HALF) c = HALF;
    return 16'(c);
  endfunction : exp_cmp

  task automatic do_reset();
    i_sys_rst = 1'b1;
    repeat (20) @(posedge i_clk);
    check("reset outputs", {31'h0, |{hi, lo, cmp, cmd, vref, uf}}, 0);
    #1 i_sys_rst = 1'b0;
  endtask : do_reset

  // Fresh random codes every cycle, converter quantises them
  task automatic rand_run(input int periods);
    for (int n = 0; n < periods * PER; n++) begin
      rng = xs(rng);
      vcode = rng[15:0];
      ccode = rng[31:16];
      @(posedge i_clk);
      #1;
    end
  endtask : rand_run

  // Port monitor: gate overlap, dead time, carrier and update timing
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      gap = 0;
      ufn = 0;
      run = 0;
      side_l = 2;
      uh = 4'h0;
      vh = 6'h00;
      cmp_l = 16'h0000;
      ref_l = 16'sh0000;
      cmd_l = 16'sh0000;
    end else begin
      gap++;
      check("gate overlap", {31'h0, hi & lo}, 0);
      check("compare span", {31'h0, cmp > HALF}, 0);
      if (cmp !== cmp_l) check("compare load", {31'h0, uh[0]}, 1);
      if (vref !== ref_l) check("ref step", {31'h0, vh[0]}, 1);
      if (cmd !== cmd_l) check("command", {31'h0, vh[4]}, 1);
      if (!hi && !lo) run++;
      else begin
        // Only a hand-over between sides shows the full dead time
        if (side_l != 2 && side_l != int'(hi)) check("dead", run, dead);
        side_l = int'(hi);
        run = 0;
      end
      uh = {uh[2:0], uf};
      vh = {vh[4:0], 1'b0};
      if (uf) begin
        ufn++;
        if (ufn > 1) check("carrier period", gap, PER);
        gap = 0;
        vh[0] = ~ufn[0];
      end
      cmp_l = cmp;
      ref_l = vref;
      cmd_l = cmd;
    end
  end

  // Hang guard, well above the planned run length
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 40000) begin
      failures++;
      close_out();
    end
  end

  initial begin
    vcode = 16'h7FC0;
    ccode = 16'h7FC0;
    dead = 8'h03;
    @(posedge i_clk);
    #1;
    do_reset();
    // Saturated loops give exact commands, compares and switch states
    for (int k = 0; k < 4; k++) begin
      vcode = vt[k];
      ccode = ct[k];
      repeat (80 * PER) @(posedge i_clk);
      #1;
      e_cmd = exp_cmd(vt[k]);
      e_cmp = exp_cmp(exp_cur(e_cmd, ct[k]));
      // On-time totals include the settling transient, so look at a delta
      snap = (e_cmp == 0) ? hi_on : lo_on;
      repeat (4 * PER) @(posedge i_clk);
      #1;
      check("current command", cmd, e_cmd);
      check("compare value", cmp, e_cmp);
      check("off switch", 16'(((e_cmp == 0) ? hi_on : lo_on) - snap), 0);
    end
    // Second reset in mid-run, then random traffic
    do_reset();
    rand_run(100);
    // Dead time settings including none at all
    for (int k = 0; k < 4; k++) begin
      dead = dts[k];
      do_reset();
      rand_run(20);
    end
    close_out();
  end
endmodule : inverter_current_mode_pi_control_tb
`default_nettype wire

// ### rtl/icp_inverter_ctrl.sv
// Two-loop current-mode inverter controller with dead-time PWM
`timescale 1ns/1ps
`default_nettype none
module icp_inverter_ctrl
  import icp_pkg::*;
#(
  parameter int unsigned P_CARRIER_HALF = ICP_CARRIER_HALF,
  parameter logic [15:0] P_PHASE_INC = ICP_PHASE_INC,
  parameter logic signed [15:0] P_SINE_AMP = ICP_SINE_AMP,
  parameter logic signed [15:0] P_VOL_UPPER_LIMIT = ICP_VOL_UPPER_LIMIT,
  parameter logic signed [15:0] P_VOL_LOWER_LIMIT = ICP_VOL_LOWER_LIMIT,
  parameter logic signed [15:0] P_CUR_UPPER_LIMIT = ICP_CUR_UPPER_LIMIT,
  parameter logic signed [15:0] P_CUR_LOWER_LIMIT = ICP_CUR_LOWER_LIMIT
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Sense codes from the converter logic, same clock
  input wire logic [15:0] i_voltage_sense_channel,
  input wire logic [15:0] i_current_sense_channel,
  // Dead time setting in clock cycles
  input wire logic [7:0] i_dead_time_control,
  // Gate drive
  output logic o_high_side_gate,
  output logic o_low_side_gate,
  // Observation
  output logic [15:0] o_inverter_compare_value,
  output logic signed [15:0] o_current_command,
  output logic signed [15:0] o_voltage_reference,
  output logic o_carrier_underflow
);
  localparam logic [ICP_CNT_W-1:0] HALF = ICP_CNT_W'(P_CARRIER_HALF);
  localparam logic [ICP_CNT_W-1:0] MID = ICP_CNT_W'(P_CARRIER_HALF / 2);

  // Whole controller state
  typedef struct packed {
    logic [ICP_CNT_W-1:0] cnt;
    logic down;
    logic uf;
    logic vturn;
    logic [15:0] phase;
    logic signed [15:0] vref;
    logic signed [15:0] vout;
    logic signed [15:0] iout;
    logic signed [15:0] verr;
    logic signed [15:0] ierr;
    logic signed [15:0] icmd;
    logic vstart;
    logic istart;
    logic [ICP_CNT_W-1:0] shadow;
    logic [ICP_CNT_W-1:0] active;
    logic pwm;
    logic [7:0] dt;
    logic hi;
    logic lo;
  } icp_ctrl_s;

  icp_ctrl_s r;
  icp_ctrl_s n;

  // Regulator answers
  logic signed [15:0] vpi_out;
  logic vpi_done;
  logic signed [15:0] ipi_out;
  logic ipi_done;

  // Saturate a 17-bit signed difference into 16 bits
  function automatic logic signed [15:0] sat16(input logic signed [16:0] x);
    if (x > 17'sh07FFF) begin
      return 16'sh7FFF;
    end else if (x < -17'sh08000) begin
      return -16'sh8000;
    end
    return x[15:0];
  endfunction : sat16

  // Decode an inverted, offset sense code into a signed sample
  function automatic logic signed [15:0] decode(input logic [15:0] code);
    return sat16($signed({1'b0, ICP_ADC_ZERO}) - $signed({1'b0, code}));
  endfunction : decode

  // Quarter-wave sine lookup, full scale 7FFFh, 64 steps a cycle
  function automatic logic signed [15:0] sine_at(input logic [15:0] ph);
    logic [3:0] idx;
    logic [15:0] mag;
    logic signed [31:0] prod;
    idx = ph[14] ? ~ph[13:10] : ph[13:10];
    case (idx)
      4'h0: mag = 16'h0000;
      4'h1: mag = 16'h0C8C;
      4'h2: mag = 16'h18F9;
      4'h3: mag = 16'h2528;
      4'h4: mag = 16'h30FB;
      4'h5: mag = 16'h3C56;
      4'h6: mag = 16'h471C;
      4'h7: mag = 16'h5133;
      4'h8: mag = 16'h5A82;
      4'h9: mag = 16'h62F1;
      4'hA: mag = 16'h6A6D;
      4'hB: mag = 16'h70E2;
      4'hC: mag = 16'h7641;
      4'hD: mag = 16'h7A7C;
      4'hE: mag = 16'h7D89;
      default: mag = 16'h7F61;
    endcase
    prod = $signed({1'b0, mag}) * P_SINE_AMP;
    prod = prod >>> 15;
    return ph[15] ? -prod[15:0] : prod[15:0];
  endfunction : sine_at

  // Map the current regulator output to an integer compare value
  function automatic logic [ICP_CNT_W-1:0] to_compare(
    input logic signed [15:0] u);
    logic signed [17:0] c;
    c = $signed({2'b00, MID}) + 18'(u >>> ICP_CMP_SHIFT);
    if (c < 18'sd0) begin
      return '0;
    end else if (c > $signed({2'b00, HALF})) begin
      return HALF;
    end
    return c[ICP_CNT_W-1:0];
  endfunction : to_compare

  // Next state for carrier, sampling, loop sequencing and gate drive
  always_comb begin
    n = r;
    n.uf = 1'b0;
    n.vstart = 1'b0;
    n.istart = 1'b0;
    // Up/down carrier; underflow flagged when the count reaches zero
    if (r.down) begin
      n.cnt = r.cnt - 1'b1;
      if (r.cnt == ICP_CNT_W'(1)) begin
        n.down = 1'b0;
        n.uf = 1'b1;
      end
    end else begin
      n.cnt = r.cnt + 1'b1;
      if (r.cnt == HALF - 1'b1) begin
        n.down = 1'b1;
      end
    end
    // Underflow: sample sense codes, start loops, load active compare
    if (r.uf) begin
      n.iout = decode(i_current_sense_channel);
      n.ierr = sat16(17'(r.icmd) - 17'(n.iout));
      n.istart = 1'b1;
      n.active = r.shadow;
      n.vturn = ~r.vturn;
      if (r.vturn) begin
        // Voltage pass on alternate samples only
        n.vout = decode(i_voltage_sense_channel);
        n.verr = sat16(17'(r.vref) - 17'(n.vout));
        n.vstart = 1'b1;
        n.phase = r.phase + P_PHASE_INC;
        n.vref = sine_at(n.phase);
      end
    end
    // Completed voltage pass becomes the current command
    if (vpi_done) begin
      n.icmd = vpi_out;
    end
    // Completed current pass lands in the shadow stage
    if (ipi_done) begin
      n.shadow = to_compare(ipi_out);
    end
    // Carrier compare with dead time counted from each edge
    n.pwm = r.active > r.cnt;
    if (n.pwm != r.pwm) begin
      n.dt = '0;
    end else if (r.dt != ICP_DT_MAX) begin
      n.dt = r.dt + 1'b1;
    end
    n.hi = n.pwm && (n.dt >= i_dead_time_control);
    n.lo = !n.pwm && (n.dt >= i_dead_time_control);
  end

  // State register
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // Outer voltage regulator
  icp_pi #(
    .P_KP(ICP_VOL_KP),
    .P_KI(ICP_VOL_KI),
    .P_KC(ICP_VOL_KC),
    .P_QP(ICP_VOL_QP),
    .P_QI(ICP_VOL_QI),
    .P_QC(ICP_VOL_QC),
    .P_UPPER_LIMIT(P_VOL_UPPER_LIMIT),
    .P_LOWER_LIMIT(P_VOL_LOWER_LIMIT)
  ) u_voltage_pi_regulator (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_start(r.vstart),
    .i_err(r.verr),
    .o_out(vpi_out),
    .o_done(vpi_done)
  );

  // Inner current regulator
  icp_pi #(
    .P_KP(ICP_CUR_KP),
    .P_KI(ICP_CUR_KI),
    .P_KC(ICP_CUR_KC),
    .P_QP(ICP_CUR_QP),
    .P_QI(ICP_CUR_QI),
    .P_QC(ICP_CUR_QC),
    .P_UPPER_LIMIT(P_CUR_UPPER_LIMIT),
    .P_LOWER_LIMIT(P_CUR_LOWER_LIMIT)
  ) u_current_pi_regulator (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_start(r.istart),
    .i_err(r.ierr),
    .o_out(ipi_out),
    .o_done(ipi_done)
  );

  assign o_high_side_gate = r.hi;
  assign o_low_side_gate = r.lo;
  assign o_inverter_compare_value = r.active;
  assign o_current_command = r.icmd;
  assign o_voltage_reference = r.vref;
  assign o_carrier_underflow = r.uf;

  // Helper: cycles since last underflow, and whether the last current start had a voltage pass
  logic [15:0] gap_r;
  logic seen_r;
  logic last_v_r;
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      gap_r <= '0;
      seen_r <= 1'b0;
      last_v_r <= 1'b0;
    end else begin
      gap_r <= r.uf ? 16'd1 : gap_r + 16'd1;
      seen_r <= seen_r | r.uf;
      if (r.istart) begin
        last_v_r <= r.vstart;
      end
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  gate_overlap_a: assert property (!(r.hi && r.lo))
    else $error("Both gates high");
  dead_gap_a: assert property (
    ($fell(r.hi) && i_dead_time_control != 8'h00) |-> !r.lo)
    else $error("Low gate on without dead time");
  carrier_period_a: assert property (
    (r.uf && seen_r) |-> gap_r == 16'(2 * P_CARRIER_HALF))
    else $error("Underflow spacing wrong");
  loop_start_a: assert property (r.uf |=> r.istart)
    else $error("Current loop not started at underflow");
  volt_alternate_a: assert property (
    (r.istart && $past(seen_r)) |-> r.vstart != last_v_r)
    else $error("Voltage loop not on alternate samples");
  shadow_load_a: assert property ($changed(r.active) |-> $past(r.uf))
    else $error("Compare changed outside underflow");
  compare_range_a: assert property (r.active <= HALF)
    else $error("Compare beyond carrier peak");
  adc_decode_a: assert property (
    r.istart |-> r.iout == decode($past(i_current_sense_channel)))
    else $error("Current sample misdecoded");
endmodule : icp_inverter_ctrl
`default_nettype wire

// ### rtl/icp_pi.sv
// PI regulator with output saturation and integral correction
`timescale 1ns/1ps
`default_nettype none
module icp_pi
  import icp_pkg::*;
#(
  parameter logic signed [15:0] P_KP = ICP_CUR_KP,
  parameter logic signed [15:0] P_KI = ICP_CUR_KI,
  parameter logic signed [15:0] P_KC = ICP_CUR_KC,
  parameter int P_QP = ICP_CUR_QP,
  parameter int P_QI = ICP_CUR_QI,
  parameter int P_QC = ICP_CUR_QC,
  parameter logic signed [15:0] P_UPPER_LIMIT = ICP_CUR_UPPER_LIMIT,
  parameter logic signed [15:0] P_LOWER_LIMIT = ICP_CUR_LOWER_LIMIT
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Request
  input wire logic i_start,
  input wire logic signed [15:0] i_err,
  // Answer
  output logic signed [15:0] o_out,
  output logic o_done
);
  // Whole regulator state
  typedef struct packed {
    icp_pi_state_e st;
    logic signed [15:0] err;
    logic signed [31:0] raw;
    logic signed [31:0] integ;
    logic signed [15:0] us;
    logic done;
  } icp_pi_s;

  icp_pi_s r;
  icp_pi_s n;

  // Coefficient product rescaled by its fractional format
  function automatic logic signed [31:0] scale_mul(
    input logic signed [15:0] k, input logic signed [31:0] x, input int q);
    logic signed [47:0] p;
    p = k * x;
    p = p >>> q;
    return p[31:0];
  endfunction : scale_mul

  // Next state: latch error, form raw and limited output, then integrate
  always_comb begin
    n = r;
    n.done = 1'b0;
    case (r.st)
      ICP_PI_IDLE: begin
        if (i_start) begin
          n.err = i_err;
          n.st = ICP_PI_RAW;
        end
      end
      ICP_PI_RAW: begin
        n.raw = scale_mul(P_KP, 32'(r.err), P_QP) + r.integ;
        if (n.raw >= 32'(P_UPPER_LIMIT)) begin
          n.us = P_UPPER_LIMIT;
        end else if (n.raw <= 32'(P_LOWER_LIMIT)) begin
          n.us = P_LOWER_LIMIT;
        end else begin
          n.us = n.raw[15:0];
        end
        n.st = ICP_PI_INTEG;
      end
      ICP_PI_INTEG: begin
        // Correction term bleeds the integral back while saturated
        n.integ = r.integ + scale_mul(P_KI, 32'(r.err), P_QI)
          + scale_mul(P_KC, 32'(r.us) - r.raw, P_QC);
        n.done = 1'b1;
        n.st = ICP_PI_IDLE;
      end
      default: begin
        n.st = ICP_PI_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign o_out = r.us;
  assign o_done = r.done;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  sequence s_go;
    i_start && r.st == ICP_PI_IDLE;
  endsequence
  // Raw output, then integral update, then the done pulse
  sequence s_finish;
    !o_done ##1 !o_done ##1 o_done;
  endsequence

  pi_done_time_a: assert property (s_go |=> s_finish)
    else $error("PI answer not three cycles after start");
  pi_out_limit_a: assert property (o_out <= P_UPPER_LIMIT && o_out >= P_LOWER_LIMIT)
    else $error("PI output outside limits");
  pi_clamp_top_a: assert property (
    (r.st == ICP_PI_RAW && (scale_mul(P_KP, 32'(r.err), P_QP) + r.integ)
      >= 32'(P_UPPER_LIMIT)) |=> o_out == P_UPPER_LIMIT)
    else $error("PI raw above limit not clamped");
endmodule : icp_pi
`default_nettype wire
